//--- core/sep_master.sv
// bus master: register port drives eeprom transfers over two-wire bus
//
// Local design decisions: the strobed register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module sep_master
    import sep_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    sep_bus_if.master bus,
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdata
);
    typedef enum logic [2:0] {
        MS_IDLE = 3'h0, MS_START = 3'h1, MS_BYTE = 3'h2, MS_ACK = 3'h3,
        MS_RSTART = 3'h4, MS_STOP = 3'h5, MS_DONE = 3'h6
    } sep_mstate_t;

    logic [7:0] dev_reg, addrHi_reg, addrLo_reg, count_reg, rdata_reg;
    logic [7:0] wdata [0:31];
    logic [1:0] kind_reg;
    logic busyFlag_reg, nackFlag_reg;
    sep_mstate_t st_reg;
    logic [8:0] tick_reg;
    logic [1:0] phase_reg;
    logic [3:0] bit_reg;
    logic [7:0] tx_reg;
    logic [5:0] byteIdx_reg;
    logic readPhase_reg;
    logic [1:0] sdaS_reg;
    logic tickDone;
    assign tickDone = tick_reg == 9'(HALF_BIT_CYCLES - 1);

    // ****************
    // register port
    // ****************
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            dev_reg <= 8'h00;
            addrHi_reg <= 8'h00;
            addrLo_reg <= 8'h00;
            count_reg <= 8'h00;
            kind_reg <= 2'h0;
            regRdata <= 8'h00;
        end else begin
            if (regWrite) begin
                case (regAddr)
                    REG_DEV: dev_reg <= regWdata;
                    REG_ADDR: addrHi_reg <= regWdata;
                    REG_WDATA: addrLo_reg <= regWdata;
                    REG_COUNT: count_reg <= regWdata;
                    REG_CTRL: kind_reg <= regWdata[CMD_KIND_HI:CMD_KIND_LO];
                    default: ;
                endcase
            end
            if (regRead) begin
                case (regAddr)
                    REG_STATUS: regRdata <= {6'h00, nackFlag_reg, busyFlag_reg};
                    REG_RDATA: regRdata <= rdata_reg;
                    REG_COUNT: regRdata <= count_reg;
                    default: regRdata <= 8'h00;
                endcase
            end else begin
                regRdata <= 8'h00;
            end
        end
    end
    // data bytes pushed at REG_RDATA offset land in the write buffer slot given by REG_COUNT
    always_ff @(posedge clk) begin
        if (regWrite && regAddr == REG_RDATA) wdata[count_reg[4:0]] <= regWdata;
    end

    // ****************
    // bit engine
    // ****************
    function automatic logic [7:0] nextByte(input logic [5:0] idx, input logic rd);
        if (idx == 6'h0) return {DEV_TYPE, dev_reg[2:0], rd};
        else if (idx == 6'h1) return addrHi_reg;
        else if (idx == 6'h2) return addrLo_reg;
        else return wdata[5'(idx - 6'h3)];
    endfunction

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) sdaS_reg <= 2'h3;
        else sdaS_reg <= {sdaS_reg[0], bus.sda};
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_reg <= MS_IDLE;
            tick_reg <= 9'h0;
            phase_reg <= 2'h0;
            bit_reg <= 4'h0;
            tx_reg <= 8'h00;
            byteIdx_reg <= 6'h0;
            readPhase_reg <= 1'b0;
            busyFlag_reg <= 1'b0;
            nackFlag_reg <= 1'b0;
            rdata_reg <= 8'h00;
            bus.sclOut <= 1'b1;
            bus.sdaMasterOe <= 1'b0;
        end else if (st_reg == MS_IDLE) begin
            tick_reg <= 9'h0;
            phase_reg <= 2'h0;
            if (regWrite && regAddr == REG_CTRL && regWdata[CMD_START]) begin
                busyFlag_reg <= 1'b1;
                nackFlag_reg <= 1'b0;
                byteIdx_reg <= 6'h0;
                readPhase_reg <= regWdata[CMD_KIND_HI:CMD_KIND_LO] == KIND_CURRENT;
                st_reg <= MS_START;
            end
        end else if (!tickDone) begin
            tick_reg <= tick_reg + 9'h1;
        end else begin
            tick_reg <= 9'h0;
            phase_reg <= phase_reg + 2'h1;
            case (st_reg)
                MS_START, MS_RSTART: begin
                    case (phase_reg)
                        2'h0: bus.sdaMasterOe <= 1'b0;
                        2'h1: bus.sclOut <= 1'b1;
                        2'h2: bus.sdaMasterOe <= 1'b1;
                        default: begin
                            bus.sclOut <= 1'b0;
                            tx_reg <= nextByte(6'h0, readPhase_reg);
                            bit_reg <= 4'h0;
                            st_reg <= MS_BYTE;
                        end
                    endcase
                end
                MS_BYTE: begin
                    // sda changes only with scl low
                    case (phase_reg)
                        2'h0: bus.sdaMasterOe <= (readPhase_reg && byteIdx_reg != 6'h0) ? 1'b0
                                                 : ~tx_reg[7];
                        2'h1: bus.sclOut <= 1'b1;
                        2'h2: tx_reg <= {tx_reg[6:0], sdaS_reg[1]};
                        default: begin
                            bus.sclOut <= 1'b0;
                            bit_reg <= bit_reg + 4'h1;
                            if (bit_reg == 4'h7) st_reg <= MS_ACK;
                        end
                    endcase
                end
                MS_ACK: begin
                    case (phase_reg)
                        2'h0: begin
                            if (readPhase_reg && byteIdx_reg != 6'h0) begin
                                rdata_reg <= tx_reg;
                                bus.sdaMasterOe <= byteIdx_reg < {1'b0, count_reg[4:0]};
                            end else begin
                                bus.sdaMasterOe <= 1'b0;
                            end
                        end
                        2'h1: bus.sclOut <= 1'b1;
                        2'h2: if (!(readPhase_reg && byteIdx_reg != 6'h0) && sdaS_reg[1])
                                  nackFlag_reg <= 1'b1;
                        default: begin
                            bus.sclOut <= 1'b0;
                            bit_reg <= 4'h0;
                            byteIdx_reg <= byteIdx_reg + 6'h1;
                            tx_reg <= nextByte(byteIdx_reg + 6'h1, readPhase_reg);
                            st_reg <= MS_BYTE;
                            // poll ends after address ack slot
                            if (nackFlag_reg || kind_reg == KIND_POLL) st_reg <= MS_STOP;
                            else if (readPhase_reg && byteIdx_reg != 6'h0 &&
                                     byteIdx_reg >= {1'b0, count_reg[4:0]}) st_reg <= MS_STOP;
                            else if (kind_reg == KIND_RANDOM && !readPhase_reg &&
                                     byteIdx_reg == 6'h2) begin
                                readPhase_reg <= 1'b1;
                                byteIdx_reg <= 6'h0;
                                st_reg <= MS_RSTART;
                            end
                            // write ends after its data bytes
                            else if (kind_reg == KIND_WRITE &&
                                     byteIdx_reg == 6'({1'b0, count_reg[4:0]} + 6'h3))
                                st_reg <= MS_STOP;
                        end
                    endcase
                end
                MS_STOP: begin
                    case (phase_reg)
                        2'h0: bus.sdaMasterOe <= 1'b1;
                        2'h1: bus.sclOut <= 1'b1;
                        2'h2: bus.sdaMasterOe <= 1'b0;
                        default: st_reg <= MS_DONE;
                    endcase
                end
                default: begin
                    busyFlag_reg <= 1'b0;
                    st_reg <= MS_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

//--- core/sep_pkg.sv
// package: constants shared by the serial eeprom slave and its bus master
package sep_pkg;
    localparam int ADDR_W = 13;
    localparam int MEM_DEPTH = 8192;
    localparam int PAGE_BITS = 5;
    localparam logic [3:0] DEV_TYPE = 4'h5; // arbitrary type code
    localparam logic [12:0] TOP_ADDR = 13'h1FFF;
    localparam int CLK_MHZ = 125;
    localparam int PROG_TIME_MS = 10;
    localparam int PROG_CYCLES = PROG_TIME_MS * 1000 * CLK_MHZ;
    localparam int HALF_BIT_CYCLES = 100;
    localparam logic DIR_WRITE = 1'b0;
    localparam logic DIR_READ = 1'b1;
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_DEV = 4'h1;
    localparam logic [3:0] REG_ADDR = 4'h2;
    localparam logic [3:0] REG_WDATA = 4'h3;
    localparam logic [3:0] REG_COUNT = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h5;
    localparam logic [3:0] REG_RDATA = 4'h6;
    localparam int CMD_START = 0;
    localparam int CMD_KIND_LO = 1;
    localparam int CMD_KIND_HI = 2;
    localparam logic [1:0] KIND_WRITE = 2'h0;
    localparam logic [1:0] KIND_RANDOM = 2'h1;
    localparam logic [1:0] KIND_CURRENT = 2'h2;
    localparam logic [1:0] KIND_POLL = 2'h3;
endpackage

//--- core/sep_bus_if.sv
// interface: two-wire bus between master and eeprom; sda open-drain, scl driven by the master
`timescale 1ns/1ps
`default_nettype none
interface sep_bus_if;
    logic sclOut;
    logic sdaMasterOe;
    logic sdaSlaveOe;
    logic scl;
    logic sda;
    assign scl = sclOut;
    assign sda = ~(sdaMasterOe | sdaSlaveOe);
    modport slave (input scl, input sda, output sdaSlaveOe);
    modport master (output sclOut, output sdaMasterOe, input scl, input sda);
endinterface
`default_nettype wire

//--- core/sep_slave.sv
// serial eeprom slave: two-wire decode, page buffer, programming timer
`timescale 1ns/1ps
`default_nettype none
module sep_slave
    import sep_pkg::*;
#(
    parameter int PROG_CYC = PROG_CYCLES
) (
    input wire logic clk,
    input wire logic nrst,
    sep_bus_if.slave bus,
    input wire logic deviceSelectBit0,
    input wire logic deviceSelectBit1,
    input wire logic deviceSelectBit2,
    input wire logic writeProtect,
    output logic busy
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0, ST_DEVADDR = 3'h1, ST_ADDRHI = 3'h2, ST_ADDRLO = 3'h3,
        ST_WDATA = 3'h4, ST_RDATA = 3'h5, ST_WAITSTOP = 3'h6
    } sep_state_t;

    // ****************
    // pin synchronisers
    // ****************
    logic [1:0] sclSync_reg, sdaSync_reg, selSync0_reg, selSync1_reg, wpSync_reg;
    logic sclD_reg, sdaD_reg;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sclSync_reg <= 2'h3;
            sdaSync_reg <= 2'h3;
            sclD_reg <= 1'b1;
            sdaD_reg <= 1'b1;
            selSync0_reg <= 2'h0;
            selSync1_reg <= 2'h0;
            wpSync_reg <= 2'h0;
        end else begin
            sclSync_reg <= {sclSync_reg[0], bus.scl};
            sdaSync_reg <= {sdaSync_reg[0], bus.sda};
            sclD_reg <= sclSync_reg[1];
            sdaD_reg <= sdaSync_reg[1];
            selSync0_reg <= {selSync0_reg[0], deviceSelectBit0};
            selSync1_reg <= {selSync1_reg[0], deviceSelectBit1};
            wpSync_reg <= {wpSync_reg[0], writeProtect};
        end
    end
    logic [1:0] selSync2_reg;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) selSync2_reg <= 2'h0;
        else selSync2_reg <= {selSync2_reg[0], deviceSelectBit2};
    end

    logic sclNow, sdaNow, sclRise, sclFall, startSeen, stopSeen;
    assign sclNow = sclSync_reg[1];
    assign sdaNow = sdaSync_reg[1];
    assign sclRise = sclNow & ~sclD_reg;
    assign sclFall = ~sclNow & sclD_reg;
    assign startSeen = sclNow & sclD_reg & sdaD_reg & ~sdaNow;
    assign stopSeen = sclNow & sclD_reg & ~sdaD_reg & sdaNow;

    // ****************
    // protocol engine
    // ****************
    logic [7:0] mem [0:MEM_DEPTH-1];
    logic [7:0] pageBuf [0:31];
    logic [31:0] pageValid_reg;
    sep_state_t state_reg;
    logic [3:0] bitCnt_reg;
    logic [7:0] shift_reg;
    logic ackPhase_reg, sdaOe_reg, dirRead_reg, nackSent_reg, gotData_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic [ADDR_W-1:0] pageBase_reg;
    logic [31:0] progCnt_reg;
    logic [2:0] strap;
    // straps sync from pins that the board pulls low
    assign strap = {selSync2_reg[1], selSync1_reg[1], selSync0_reg[1]};
    assign bus.sdaSlaveOe = sdaOe_reg;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= ST_IDLE;
            bitCnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            ackPhase_reg <= 1'b0;
            sdaOe_reg <= 1'b0;
            dirRead_reg <= 1'b0;
            nackSent_reg <= 1'b0;
            gotData_reg <= 1'b0;
            addr_reg <= '0;
            pageBase_reg <= '0;
            pageValid_reg <= 32'h0;
            busy <= 1'b0;
            progCnt_reg <= 32'h0;
        end else if (busy) begin
            // interface off while programming; no ack; bounded time
            sdaOe_reg <= 1'b0;
            state_reg <= ST_IDLE;
            if (progCnt_reg >= 32'(PROG_CYC - 1)) begin
                busy <= 1'b0;
                progCnt_reg <= 32'h0;
                pageValid_reg <= 32'h0;
            end else begin
                progCnt_reg <= progCnt_reg + 32'h1;
            end
        end else if (startSeen) begin
            state_reg <= ST_DEVADDR;
            bitCnt_reg <= 4'h0;
            ackPhase_reg <= 1'b0;
            sdaOe_reg <= 1'b0;
        end else if (stopSeen) begin
            sdaOe_reg <= 1'b0;
            state_reg <= ST_IDLE;
            // program only after stop, buffered page bytes one per cycle
            if (gotData_reg && !nackSent_reg) busy <= 1'b1;
            gotData_reg <= 1'b0;
            nackSent_reg <= 1'b0;
        end else if (state_reg != ST_IDLE && state_reg != ST_WAITSTOP) begin
            if (sclRise && !ackPhase_reg) begin
                if (state_reg != ST_RDATA) shift_reg <= {shift_reg[6:0], sdaNow};
                bitCnt_reg <= bitCnt_reg + 4'h1;
            end else if (sclRise && ackPhase_reg && state_reg == ST_RDATA && !sdaOe_reg) begin
                // master ack continues, nack waits for stop
                if (sdaNow) state_reg <= ST_WAITSTOP;
            end else if (sclFall && ackPhase_reg) begin
                ackPhase_reg <= 1'b0;
                bitCnt_reg <= 4'h0;
                sdaOe_reg <= 1'b0;
                if (state_reg == ST_RDATA) begin
                    sdaOe_reg <= ~mem[addr_reg][7];
                    shift_reg <= {mem[addr_reg][6:0], 1'b1};
                    // counter lands one past the byte sent; full width
                    addr_reg <= (addr_reg == TOP_ADDR) ? '0 : addr_reg + 1'b1;
                end
            end else if (sclFall && state_reg == ST_RDATA && bitCnt_reg != 4'h8) begin
                sdaOe_reg <= ~shift_reg[7];
                shift_reg <= {shift_reg[6:0], 1'b1};
            end else if (sclFall && bitCnt_reg == 4'h8) begin
                ackPhase_reg <= 1'b1;
                sdaOe_reg <= 1'b0;
                case (state_reg)
                    ST_DEVADDR: begin
                        // type code and straps; direction bit
                        if (shift_reg[7:4] == DEV_TYPE && shift_reg[3:1] == strap) begin
                            sdaOe_reg <= 1'b1;
                            dirRead_reg <= shift_reg[0];
                            state_reg <= (shift_reg[0] == DIR_READ) ? ST_RDATA : ST_ADDRHI;
                        end else begin
                            state_reg <= ST_WAITSTOP;
                        end
                    end
                    ST_ADDRHI: begin
                        // high byte first, excess bits dropped; ack
                        addr_reg[12:8] <= shift_reg[4:0];
                        sdaOe_reg <= 1'b1;
                        state_reg <= ST_ADDRLO;
                    end
                    ST_ADDRLO: begin
                        addr_reg[7:0] <= shift_reg;
                        pageBase_reg <= {addr_reg[12:8], shift_reg[7:5], 5'h00};
                        sdaOe_reg <= 1'b1;
                        state_reg <= ST_WDATA;
                    end
                    ST_WDATA: begin
                        // write protect refuses the first data byte
                        if (wpSync_reg[1]) begin
                            nackSent_reg <= 1'b1;
                            state_reg <= ST_WAITSTOP;
                        end else begin
                            // low five bits wrap; later bytes overwrite
                            pageBuf[addr_reg[4:0]] <= shift_reg;
                            pageValid_reg[addr_reg[4:0]] <= 1'b1;
                            addr_reg[4:0] <= addr_reg[4:0] + 5'h01;
                            gotData_reg <= 1'b1;
                            sdaOe_reg <= 1'b1;
                        end
                    end
                    ST_RDATA: begin
                        state_reg <= ST_RDATA;
                    end
                    default: state_reg <= ST_WAITSTOP;
                endcase
            end
        end
    end

    // ****************
    // array commit
    // ****************
    // one byte per cycle keeps a single array write port; PROG_CYC must be 32 or more
    always_ff @(posedge clk) begin
        if (busy && progCnt_reg < 32'(1 << PAGE_BITS) && pageValid_reg[progCnt_reg[4:0]]) begin
            mem[{pageBase_reg[12:5], progCnt_reg[4:0]}] <= pageBuf[progCnt_reg[4:0]];
        end
    end
endmodule
`default_nettype wire

//--- test/sep_monitor.sv
// checker: slave behaviour on the shared two-wire bus
`timescale 1ns/1ps
`default_nettype none
module sep_monitor
    import sep_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic scl,
    input wire logic sda,
    input wire logic sdaSlaveOe
);
    // ****************************************
    // bit and byte position since last start or stop
    // ****************************************
    logic sclQ, sdaQ, doneRd;
    logic [3:0] bitPos;
    logic [1:0] byteNo;
    logic [7:0] shAddr;
    wire logic frameEv = sclQ && scl && (sdaQ != sda);
    wire logic sclRise = !sclQ && scl;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sclQ <= 1'b1;
            sdaQ <= 1'b1;
        end else begin
            sclQ <= scl;
            sdaQ <= sda;
        end
    end
    // start and stop both restart the count
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            bitPos <= 4'h0;
            byteNo <= 2'h0;
            doneRd <= 1'b0;
        end else if (frameEv) begin
            bitPos <= 4'h0;
            byteNo <= 2'h0;
            doneRd <= 1'b0;
        end else if (sclRise) begin
            bitPos <= (bitPos == 4'h9) ? 4'h1 : bitPos + 4'h1;
            if (bitPos == 4'h9 && byteNo != 2'h3) begin
                byteNo <= byteNo + 2'h1;
            end
            if (bitPos == 4'h8 && byteNo != 2'h0 && shAddr[0] && sda) begin
                doneRd <= 1'b1;
            end
        end
    end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            shAddr <= 8'h00;
        end else if (sclRise && byteNo == 2'h0 && bitPos < 4'h8) begin
            shAddr <= {shAddr[6:0], sda};
        end
    end
    // ****************************************
    // properties
    // ****************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    a_scl_high_min: assert property ($rose(scl) |-> scl [*8])
        else $error("clock high phase too short");
    a_scl_low_min: assert property ($fell(scl) |-> !scl [*8])
        else $error("clock low phase too short");
    a_slave_steady: assert property (scl && $past(scl) |-> $stable(sdaSlaveOe))
        else $error("slave moved data while clock high");
    a_addr_bits_free: assert property (scl && sclQ && byteNo == 2'h0 && bitPos inside {[1:8]}
        |-> !sdaSlaveOe)
        else $error("slave drove during address bits");
    a_ack_type_match: assert property (scl && byteNo == 2'h0 && bitPos == 4'h9 && sdaSlaveOe
        |-> shAddr[7:4] == DEV_TYPE)
        else $error("slave acknowledged a foreign type code");
    a_write_data_free: assert property (scl && sclQ && byteNo != 2'h0 && bitPos inside {[1:8]}
        && !shAddr[0] |-> !sdaSlaveOe)
        else $error("slave drove during written data bits");
    a_read_ack_free: assert property (scl && sclQ && byteNo != 2'h0 && bitPos == 4'h9 && shAddr[0]
        |-> !sdaSlaveOe)
        else $error("slave held data during master ack slot");
    a_nack_silence: assert property (doneRd |-> !sdaSlaveOe)
        else $error("slave kept sending after master nack");
    c_addr_ack: cover property (scl && byteNo == 2'h0 && bitPos == 4'h9 && sdaSlaveOe);
    c_data_ack: cover property (scl && byteNo != 2'h0 && bitPos == 4'h9 && sdaSlaveOe);
    c_read_end: cover property (doneRd);
endmodule
`default_nettype wire

//--- test/tb_top.sv
// testbench: bus master and eeprom slave joined on one two-wire bus
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import sep_pkg::*;
    localparam int PROG = 4600;
    localparam int LIMIT = 100000;
    logic clk, nrst, regWrite, regRead, wp, busy;
    logic [3:0] regAddr;
    logic [7:0] regWdata, regRdata, st, got, d0, d1, d2, hi;
    logic [2:0] straps;
    logic [12:0] pa;
    int errors, n_checks;
    sep_bus_if bus();
    sep_slave #(.PROG_CYC(PROG)) u_sep_slave (.clk(clk), .nrst(nrst), .bus(bus),
        .deviceSelectBit0(straps[0]), .deviceSelectBit1(straps[1]),
        .deviceSelectBit2(straps[2]), .writeProtect(wp), .busy(busy));
    sep_master u_sep_master (.clk(clk), .nrst(nrst), .bus(bus), .regAddr(regAddr),
        .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata));
    sep_monitor u_sep_monitor (.clk(clk), .nrst(nrst), .scl(bus.scl), .sda(bus.sda),
        .sdaSlaveOe(bus.sdaSlaveOe));
    // ****************************************
    // expectations and bus tasks
    // ****************************************
    function automatic logic [12:0] pageAddr(input logic [12:0] b, input logic [4:0] i);
        return {b[12:5], b[4:0] + i};
    endfunction
    function automatic logic [7:0] expNack(input logic w, input logic m, input logic b);
        return {7'h00, w | !m | b};
    endfunction
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        #1 d = regRdata;
    endtask
    // one transfer, then wait for the master to go idle
    task automatic run(input logic [1:0] kind);
        int i;
        wr(REG_CTRL, {5'h00, kind, 1'b1});
        for (i = 0; i < 30000; i++) begin
            rd(REG_STATUS, st);
            if (st[0] === 1'b0) break;
        end
        if (st[0] !== 1'b0) begin
            errors++;
            $display("BAD transfer end expected 0 seen %b", st[0]);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // ****************************************
    // clock, timeout, tests
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        repeat (LIMIT) @(posedge clk);
        errors++;
        end_sim();
    end
    initial begin
        nrst = 1'b0;
        regAddr = 4'h0;
        regWdata = 8'h00;
        regWrite = 1'b0;
        regRead = 1'b0;
        wp = 1'b0;
        errors = 0;
        n_checks = 0;
        void'($urandom(23478));
        straps = 3'($urandom);
        d0 = 8'($urandom);
        d1 = 8'($urandom);
        d2 = 8'($urandom);
        hi = 8'($urandom);
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        // page write starting at the last slot of a page
        wr(REG_DEV, {5'h00, straps});
        wr(REG_ADDR, hi);
        wr(REG_WDATA, 8'hFF);
        wr(REG_COUNT, 8'h00);
        wr(REG_RDATA, d0);
        wr(REG_COUNT, 8'h01);
        wr(REG_RDATA, d1);
        wr(REG_COUNT, 8'h02);
        wr(REG_RDATA, d2);
        run(KIND_WRITE);
        chk("write nack", expNack(1'b0, 1'b1, 1'b0), {7'h00, st[1]});
        repeat (8) @(posedge clk);
        chk("busy after stop", 8'h01, {7'h00, busy});
        $display("page write done");
        run(KIND_POLL);
        chk("poll while busy", expNack(1'b0, 1'b1, 1'b1), {7'h00, st[1]});
        run(KIND_POLL);
        chk("poll when done", expNack(1'b0, 1'b1, 1'b0), {7'h00, st[1]});
        $display("polling done");
        // second byte must have wrapped to slot zero; spare high bits flipped
        pa = pageAddr({hi[4:0], 8'hFF}, 5'h01);
        wr(REG_ADDR, {~hi[7:5], pa[12:8]});
        wr(REG_WDATA, pa[7:0]);
        wr(REG_COUNT, 8'h00);
        run(KIND_RANDOM);
        rd(REG_RDATA, got);
        chk("wrapped byte", d1, got);
        run(KIND_CURRENT);
        rd(REG_RDATA, got);
        chk("current byte", d2, got);
        $display("random and current read done");
        wr(REG_DEV, {5'h00, straps ^ 3'h1});
        run(KIND_POLL);
        chk("foreign strap", expNack(1'b0, 1'b0, 1'b0), {7'h00, st[1]});
        $display("strap mismatch done");
        @(posedge clk);
        wp <= 1'b1;
        wr(REG_DEV, {5'h00, straps});
        wr(REG_RDATA, 8'($urandom));
        run(KIND_WRITE);
        chk("protected nack", expNack(1'b1, 1'b1, 1'b0), {7'h00, st[1]});
        repeat (8) @(posedge clk);
        chk("protected busy", 8'h00, {7'h00, busy});
        $display("write protect done");
        end_sim();
    end
endmodule
`default_nettype wire
